/* design/bus_sizing_pkg.sv */
// constants for the dynamic bus sizing cycle engine
package bus_sizing_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  // transfer size encodings on the size outputs
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  // acknowledge pair {high, low} decodes
  localparam logic [1:0] ACK_WAIT = 2'h0;
  localparam logic [1:0] ACK_PORT8 = 2'h1;
  localparam logic [1:0] ACK_PORT16 = 2'h2;
  localparam logic [1:0] ACK_PORT32 = 2'h3;
  // request kinds
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_IACK = 2'h1;
  // completion status
  localparam logic [1:0] STAT_OK = 2'h0;
  localparam logic [1:0] STAT_BUS_ERROR_IN = 2'h1;
  localparam logic [1:0] STAT_RETRY = 2'h2;
  localparam logic [1:0] STAT_AUTOVEC = 2'h3;
  // autovector base number, level from address bits 3:1 added to it
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;
  localparam int BUF_DEPTH = 2;
endpackage

/* design/skid_buffer.sv */
// two-entry buffer between the cycle engine and the result consumer
`timescale 1ns/1ps
module skid_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = bus_sizing_pkg::BUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* design/byte_router.sv */
// operand byte to data lane routing for writes and lane extraction for reads
`timescale 1ns/1ps
module byte_router (
  input wire logic [1:0] size_i,
  input wire logic [1:0] offset_i,
  input wire logic [31:0] operand_i,
  input wire logic [31:0] bus_i,
  input wire logic [1:0] port_i,
  output logic [31:0] wr_lanes_o,
  output logic [31:0] rd_bytes_o,
  output logic [2:0] moved_o
);
  // byte j of operand (0 = msb) at lane k (0 = bits 31:24)
  function automatic logic [7:0] op_byte(input logic [31:0] op,
                                         input logic [1:0] idx);
    return op[8*(3-idx) +: 8];
  endfunction

  logic [2:0] rem;
  logic [1:0] first;
  logic [2:0] lanes;
  logic [2:0] room;

  always_comb begin
    rem = (size_i == bus_sizing_pkg::SIZE_LONG) ? 3'h4 : {1'b0, size_i};
    first = 2'(3'h4 - rem);
    wr_lanes_o = '0;
    rd_bytes_o = '0;
    // remaining bytes are the low end of the operand
    for (int k = 0; k < 4; k++) begin
      // lanes below the offset carry what a narrower port would need
      // there, so every port width finds its byte on its own lanes
      if (k >= int'(offset_i)) begin
        wr_lanes_o[8*(3-k) +: 8] =
          op_byte(operand_i, 2'(first + 2'(k) - offset_i));
      end else if (k < 2 && k >= int'(offset_i[0])) begin
        wr_lanes_o[8*(3-k) +: 8] = op_byte(operand_i,
          2'(first + 2'(k) - {1'b0, offset_i[0]}));
      end else begin
        wr_lanes_o[8*(3-k) +: 8] = op_byte(operand_i, first);
      end
    end
    // lanes usable from offset given port width
    case (port_i)
      bus_sizing_pkg::ACK_PORT8: room = 3'h1;
      bus_sizing_pkg::ACK_PORT16: room = 3'h2 - {2'h0, offset_i[0]};
      default: room = 3'h4 - {1'b0, offset_i};
    endcase
    lanes = (room < rem) ? room : rem;
    moved_o = lanes;
    // read: gather the moved bytes into operand position
    for (int j = 0; j < 4; j++) begin
      if (3'(j) < lanes) begin
        case (port_i)
          bus_sizing_pkg::ACK_PORT8:
            rd_bytes_o[8*(3-(first+j)) +: 8] = bus_i[31:24];
          bus_sizing_pkg::ACK_PORT16:
            rd_bytes_o[8*(3-(first+j)) +: 8] =
              bus_i[8*(3-(offset_i[0]+j)) +: 8];
          default:
            rd_bytes_o[8*(3-(first+j)) +: 8] =
              bus_i[8*(3-(offset_i+j)) +: 8];
        endcase
      end
    end
  end
endmodule

/* design/bus_cycle_engine.sv */
// asynchronous bus cycle engine with dynamic port sizing
`timescale 1ns/1ps
module bus_cycle_engine (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // operand request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic [1:0] req_kind_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  // result
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [31:0] rsp_rdata_o,
  output logic [1:0] rsp_status_o,
  // external bus
  output logic [31:0] addr_o,
  output logic xfer_size_high_o,
  output logic xfer_size_low_o,
  output logic read_write_o,
  output logic address_strobe_n_o,
  output logic data_strobe_n_o,
  output logic data_buffer_enable_n_o,
  output logic [31:0] data_o,
  output logic data_oe_o,
  input wire logic [31:0] data_i,
  input wire logic port_ack_high_n_i,
  input wire logic port_ack_low_n_i,
  input wire logic bus_error_in_n_i,
  input wire logic halt_n_i,
  input wire logic autovector_request_n_i
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_START, ST_STROBE, ST_WAIT, ST_END,
                ST_DONE} state_t;

  logic rst_meta_q;
  logic rst_n_q;
  state_t state_q;
  logic write_q;
  logic iack_q;
  logic [1:0] size_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [1:0] status_q;
  logic [1:0] port_q;
  logic data_buffer_enable_q;
  logic as_q;
  logic ds_q;
  logic oe_q;
  logic [31:0] lanes_q;
  logic [1:0] ack;
  logic bus_error_in;
  logic halt;
  logic autovector_request_hit;
  logic term;
  logic [31:0] wr_lanes;
  logic [31:0] rd_bytes;
  logic [2:0] moved;
  logic [2:0] rem;
  logic buf_ready;
  logic [33:0] buf_out;
  logic take;
  logic ok_end;
  logic more;

  // bytes still owed by the operand, long word coded as zero
  function automatic logic [2:0] size_bytes(input logic [1:0] code);
    return (code == bus_sizing_pkg::SIZE_LONG) ? 3'h4 : {1'b0, code};
  endfunction

  // synchronous input assumption; reset released through two stages
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // termination decode
  assign ack = {~port_ack_high_n_i, ~port_ack_low_n_i};
  assign bus_error_in = ~bus_error_in_n_i;
  assign halt = ~halt_n_i;
  assign autovector_request_hit = iack_q && ~autovector_request_n_i;
  assign term = (ack != bus_sizing_pkg::ACK_WAIT) || bus_error_in || autovector_request_hit;
  assign rem = size_bytes(size_q);
  assign take = (state_q == ST_IDLE) && req_valid_i && buf_ready;
  assign ok_end = (state_q == ST_END)
                  && (status_q == bus_sizing_pkg::STAT_OK);
  assign more = (moved < rem);
  assign req_ready_o = (state_q == ST_IDLE) && buf_ready;

  byte_router u_router (
    .size_i(size_q),
    .offset_i(addr_q[1:0]),
    .operand_i(wdata_q),
    .bus_i(data_i),
    .port_i(port_q),
    .wr_lanes_o(wr_lanes),
    .rd_bytes_o(rd_bytes),
    .moved_o(moved)
  );

  ////////////////////////////////////////////////////////////////////////
  // cycle sequencing
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_START;
          end
        end
        ST_START: state_q <= ST_STROBE;
        ST_STROBE: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (term) begin
            state_q <= ST_END;
          end
        end
        ST_END: begin
          // error endings never continue, whatever bytes are left
          if (ok_end && more) begin
            state_q <= ST_START;
          end else begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // operand kept for all cycles of the transfer
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      write_q <= 1'b0;
      iack_q <= 1'b0;
      wdata_q <= '0;
    end else if (take) begin
      write_q <= req_write_i;
      iack_q <= (req_kind_i == bus_sizing_pkg::KIND_IACK);
      wdata_q <= req_wdata_i;
    end
  end

  // size and address of the next cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      size_q <= bus_sizing_pkg::SIZE_LONG;
      addr_q <= '0;
    end else if (take) begin
      size_q <= req_size_i;
      addr_q <= req_addr_i;
    end else if (ok_end && more) begin
      // at least one byte moved, so the rest fits two bits
      size_q <= 2'(rem - moved);
      addr_q <= addr_q + {29'h0, moved};
    end
  end

  // termination status and reported port width
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= bus_sizing_pkg::STAT_OK;
      port_q <= bus_sizing_pkg::ACK_PORT32;
    end else if (take) begin
      status_q <= bus_sizing_pkg::STAT_OK;
      port_q <= bus_sizing_pkg::ACK_PORT32;
    end else if (state_q == ST_WAIT && term) begin
      // bus error outranks any acknowledge seen with it
      if (bus_error_in && halt) begin
        status_q <= bus_sizing_pkg::STAT_RETRY;
      end else if (bus_error_in) begin
        status_q <= bus_sizing_pkg::STAT_BUS_ERROR_IN;
      end else if (autovector_request_hit) begin
        status_q <= bus_sizing_pkg::STAT_AUTOVEC;
      end else begin
        port_q <= ack;
      end
    end
  end

  // read data gathered over the cycles of one operand
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else if (take) begin
      rdata_q <= '0;
    end else if (state_q == ST_WAIT && term && !bus_error_in && autovector_request_hit) begin
      rdata_q <= {24'h0, bus_sizing_pkg::AUTOVEC_BASE
                  + {5'h0, addr_q[3:1]}};
    end else if (ok_end && !write_q) begin
      rdata_q <= rdata_q | rd_bytes;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobes, buffer enable and data drive
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      as_q <= 1'b0;
      ds_q <= 1'b0;
      data_buffer_enable_q <= 1'b0;
      oe_q <= 1'b0;
      lanes_q <= '0;
    end else begin
      case (state_q)
        ST_START: begin
          as_q <= 1'b1;
          ds_q <= !write_q;
          data_buffer_enable_q <= write_q;
          oe_q <= write_q;
          lanes_q <= wr_lanes;
        end
        ST_STROBE: begin
          ds_q <= 1'b1;
          data_buffer_enable_q <= 1'b1;
        end
        ST_WAIT: begin
          if (term) begin
            as_q <= 1'b0;
            ds_q <= 1'b0;
            data_buffer_enable_q <= 1'b0;
          end
        end
        default: begin
          // drive released after the cycle's strobes are gone
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign addr_o = addr_q;
  assign {xfer_size_high_o, xfer_size_low_o} = size_q;
  assign read_write_o = ~write_q;
  assign address_strobe_n_o = ~as_q;
  assign data_strobe_n_o = ~ds_q;
  assign data_buffer_enable_n_o = ~data_buffer_enable_q;
  assign data_o = lanes_q;
  assign data_oe_o = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // result path; full buffer holds off new requests
  skid_buffer #(
    .WIDTH(34),
    .DEPTH(bus_sizing_pkg::BUF_DEPTH)
  ) u_buf (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_q),
    .in_valid_i(state_q == ST_DONE),
    .in_ready_o(buf_ready),
    .in_data_i({status_q, rdata_q}),
    .out_valid_o(rsp_valid_o),
    .out_ready_i(rsp_ready_i),
    .out_data_o(buf_out)
  );
  assign rsp_status_o = buf_out[33:32];
  assign rsp_rdata_o = buf_out[31:0];
endmodule

/* verif/bus_cycle_engine_assertions.sv */
// concurrent checks on the bus cycle engine ports
`timescale 1ns/1ps
module bus_cycle_engine_assertions (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [31:0] addr_o,
  input wire logic xfer_size_high_o,
  input wire logic xfer_size_low_o,
  input wire logic read_write_o,
  input wire logic address_strobe_n_o,
  input wire logic data_strobe_n_o,
  input wire logic data_buffer_enable_n_o,
  input wire logic data_oe_o,
  input wire logic port_ack_high_n_i,
  input wire logic port_ack_low_n_i,
  input wire logic bus_error_in_n_i,
  input wire logic autovector_request_n_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_read_data_buffer_enable_late:
  assert property ($fell(address_strobe_n_o) && read_write_o
    |-> data_buffer_enable_n_o ##1 !data_buffer_enable_n_o)
    else $error("read buffer enable not one clock late");
  chk_write_data_buffer_enable_as:
  assert property (!read_write_o
    |-> address_strobe_n_o == data_buffer_enable_n_o)
    else $error("write buffer enable differs from address strobe");
  chk_write_drive_all:
  assert property (!address_strobe_n_o && !read_write_o |-> data_oe_o)
    else $error("write cycle without data drive");
  chk_ack_ends_cycle:
  assert property (!address_strobe_n_o && !data_strobe_n_o
    && !port_ack_high_n_i |-> ##[1:4] address_strobe_n_o)
    else $error("acknowledge did not end the cycle");
  chk_wait_holds_cycle:
  assert property (!address_strobe_n_o && port_ack_high_n_i
    && port_ack_low_n_i && bus_error_in_n_i && autovector_request_n_i
    |=> !address_strobe_n_o)
    else $error("cycle ended without termination");
  chk_bus_error_in_ends_cycle:
  assert property (!address_strobe_n_o && !bus_error_in_n_i
    |-> ##[1:4] address_strobe_n_o)
    else $error("bus error did not end the cycle");
  chk_word_port_next:
  assert property ($rose(address_strobe_n_o) && $past({xfer_size_high_o,
    xfer_size_low_o, addr_o[1:0]}) == 4'h0 && $past({port_ack_high_n_i,
    port_ack_low_n_i, bus_error_in_n_i}) == 3'h3 |-> ##[1:6]
    (!address_strobe_n_o && {xfer_size_high_o, xfer_size_low_o,
    addr_o[1:0]} == 4'ha))
    else $error("word port long word not continued");
  chk_byte_port_next:
  assert property ($rose(address_strobe_n_o) && $past({xfer_size_high_o,
    xfer_size_low_o, addr_o[1:0]}) == 4'h0 && $past({port_ack_high_n_i,
    port_ack_low_n_i, bus_error_in_n_i}) == 3'h5 |-> ##[1:6]
    (!address_strobe_n_o && {xfer_size_high_o, xfer_size_low_o,
    addr_o[1:0]} == 4'hd))
    else $error("byte port long word not continued");
endmodule
bind bus_cycle_engine bus_cycle_engine_assertions chk_inst (.*);

/* verif/bus_port_model.sv */
// far-side port: byte memory of selectable width and termination
`timescale 1ns/1ps
module bus_port_model (
  input wire logic clk_i,
  input wire logic [31:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic rw_i,
  input wire logic as_n_i,
  input wire logic [31:0] wdata_i,
  input wire logic [1:0] width_i,
  input wire logic [1:0] term_i,
  input wire logic [3:0] waits_i,
  output logic [31:0] rdata_o,
  output logic ack_high_n_o,
  output logic ack_low_n_o,
  output logic bus_error_in_n_o,
  output logic halt_n_o,
  output logic autovector_request_n_o
);
  logic [7:0] mem [16];
  logic [3:0] cnt, a;
  int lim, n;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'ha0 + 8'(i);
    {ack_high_n_o, ack_low_n_o, bus_error_in_n_o, halt_n_o, autovector_request_n_o} = 5'h1f;
    rdata_o = 32'h0;
    cnt = 4'h0;
  end
  always @(posedge clk_i) begin
    lim = (width_i == 2'h3) ? 4 : int'(width_i);
    n = (size_i == 2'h0) ? 4 : int'(size_i);
    if (as_n_i) begin
      cnt <= 4'h0;
      {ack_high_n_o, ack_low_n_o, bus_error_in_n_o, halt_n_o, autovector_request_n_o} <= 5'h1f;
      rdata_o <= ~rdata_o; // released lines must not keep old data
    end else if (cnt < waits_i) begin
      cnt <= cnt + 4'h1;
    end else if (cnt == waits_i) begin
      cnt <= cnt + 4'h1;
      for (int k = 0; k < lim; k++) begin
        a = (lim == 4) ? {addr_i[3:2], 2'(k)} :
          (lim == 2) ? {addr_i[3:1], 1'(k)} : addr_i[3:0];
        rdata_o[31-8*k -: 8] <= mem[a];
        if (!rw_i && term_i == 2'h0 && a >= addr_i[3:0]
            && a < addr_i[3:0] + n)
          mem[a] <= wdata_i[31-8*k -: 8];
      end
      case (term_i)
        2'h0: {ack_high_n_o, ack_low_n_o} <= ~width_i;
        2'h1: bus_error_in_n_o <= 1'b0;
        2'h2: {bus_error_in_n_o, halt_n_o} <= 2'h0;
        default: autovector_request_n_o <= 1'b0;
      endcase
    end
  end
endmodule

/* verif/dynamic_bus_sizing_termination_tb.sv */
// self-checking bench for the bus cycle engine
`timescale 1ns/1ps
module dynamic_bus_sizing_termination_tb;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_ready_o, req_write_i, rsp_valid_o, rsp_ready_i, read_write_o;
  logic xfer_size_high_o, xfer_size_low_o, address_strobe_n_o, halt_n_i;
  logic data_strobe_n_o, data_buffer_enable_n_o, data_oe_o;
  logic port_ack_high_n_i, port_ack_low_n_i, bus_error_in_n_i;
  logic autovector_request_n_i;
  logic [1:0] req_kind_i, req_size_i, rsp_status_o, st, width, term;
  logic [31:0] req_addr_i, req_wdata_i, rsp_rdata_o, addr_o, data_o;
  logic [31:0] data_i, rd;
  logic [3:0] waits;
  int n_mismatch = 0;
  int check_count = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  bus_cycle_engine bus_cycle_engine_inst (.*);
  bus_port_model bus_port_model_inst (.clk_i(ref_clk_i), .addr_i(addr_o),
    .size_i({xfer_size_high_o, xfer_size_low_o}), .rw_i(read_write_o),
    .as_n_i(address_strobe_n_o), .wdata_i(data_o), .width_i(width),
    .term_i(term), .waits_i(waits), .rdata_o(data_i),
    .ack_high_n_o(port_ack_high_n_i), .ack_low_n_o(port_ack_low_n_i),
    .bus_error_in_n_o(bus_error_in_n_i), .halt_n_o(halt_n_i),
    .autovector_request_n_o(autovector_request_n_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp_d(input logic [31:0] e);
    check_count++;
    if (rd !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t data %h exp %h", $time, rd, e);
    end
  endtask
  task automatic cmp_s(input logic [1:0] e);
    check_count++;
    if (st !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t status %h exp %h", $time, st, e);
    end
  endtask
  // one operand, bounded waits on both handshakes
  task automatic op(input logic w, input logic [1:0] k, s,
                    input logic [31:0] a, d);
    int t;
    t = 0;
    {req_write_i, req_kind_i, req_size_i} = {w, k, s};
    {req_addr_i, req_wdata_i} = {a, d};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && t < 99) begin
      t++;
      @(negedge ref_clk_i);
    end
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && t < 300) begin
      t++;
      @(negedge ref_clk_i);
    end
    if (t >= 300) begin
      n_mismatch++;
      $display("MISMATCH %0t no answer", $time);
    end
    {rd, st} = {rsp_rdata_o, rsp_status_o};
    @(negedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_wide_read;
    rsp_ready_i = 1'b0;
    op(1'b0, 2'h0, 2'h0, 32'h4, 32'h0);
    rd = rsp_rdata_o; // consumer stalled: buffer must still hold it
    cmp_d(32'ha4a5a6a7);
    rsp_ready_i = 1'b1;
    @(negedge ref_clk_i);
    op(1'b0, 2'h0, 2'h2, 32'h6, 32'h0);
    cmp_d(32'ha6a7);
    op(1'b0, 2'h0, 2'h1, 32'h5, 32'h0);
    cmp_d(32'ha5);
    cmp_s(bus_sizing_pkg::STAT_OK);
  endtask
  task automatic t_narrow_read;
    {width, waits} = {2'h2, 4'h2};
    op(1'b0, 2'h0, 2'h0, 32'h0, 32'h0);
    cmp_d(32'ha0a1a2a3);
    width = 2'h1;
    op(1'b0, 2'h0, 2'h0, 32'h8, 32'h0);
    cmp_d(32'ha8a9aaab);
    waits = 4'h0;
  endtask
  task automatic t_write;
    op(1'b1, 2'h0, 2'h0, 32'h0, 32'h11223344);
    width = 2'h2;
    op(1'b1, 2'h0, 2'h2, 32'h5, 32'h5566);
    width = 2'h3;
    op(1'b0, 2'h0, 2'h0, 32'h0, 32'h0);
    cmp_d(32'h11223344);
    op(1'b0, 2'h0, 2'h0, 32'h4, 32'h0);
    cmp_d(32'ha45566a7);
  endtask
  task automatic t_terms;
    term = 2'h1;
    op(1'b0, 2'h0, 2'h0, 32'h4, 32'h0);
    cmp_s(bus_sizing_pkg::STAT_BUS_ERROR_IN);
    term = 2'h2;
    op(1'b0, 2'h0, 2'h0, 32'h4, 32'h0);
    cmp_s(bus_sizing_pkg::STAT_RETRY);
    term = 2'h3;
    op(1'b0, 2'h1, 2'h1, 32'h6, 32'h0);
    cmp_s(bus_sizing_pkg::STAT_AUTOVEC);
    cmp_d({24'h0, bus_sizing_pkg::AUTOVEC_BASE + 8'h3});
    term = 2'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {req_write_i, req_kind_i, req_size_i} = 5'h0;
    {req_addr_i, req_wdata_i} = 64'h0;
    rsp_ready_i = 1'b1;
    {width, term, waits} = {2'h3, 2'h0, 4'h0};
    repeat (8) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    t_wide_read();
    t_narrow_read();
    t_write();
    t_terms();
    test_done();
  end
  initial begin
    #200us;
    n_mismatch++;
    test_done();
  end
endmodule
